// File: inc/lrtc_params.svh
// constants of the logger clock/alarm register page
// assumes a 200 MHz core clock and byte-wide register access
`ifndef LRTC_PARAMS_SVH
`define LRTC_PARAMS_SVH
// register offsets
`define LRTC_A_SEC   16'h0200
`define LRTC_A_MIN   16'h0201
`define LRTC_A_HR    16'h0202
`define LRTC_A_WDAY  16'h0203
`define LRTC_A_DATE  16'h0204
`define LRTC_A_MON   16'h0205
`define LRTC_A_YR    16'h0206
`define LRTC_A_ASEC  16'h0207
`define LRTC_A_AMIN  16'h0208
`define LRTC_A_AHR   16'h0209
`define LRTC_A_AWDAY 16'h020A
`define LRTC_A_TLOW  16'h020B
`define LRTC_A_THIGH 16'h020C
`define LRTC_A_RATE  16'h020D
`define LRTC_A_CTRL  16'h020E
`define LRTC_A_TEMP  16'h0211
`define LRTC_A_STAT  16'h0214
// writable-bit masks, fixed zeros elsewhere
`define LRTC_M_SEC   8'h7F
`define LRTC_M_HR    8'h7F
`define LRTC_M_WDAY  8'h07
`define LRTC_M_DATE  8'h3F
`define LRTC_M_MON   8'h9F
`define LRTC_M_AWDAY 8'h87
`define LRTC_M_CTRL  8'hDF
// field positions
`define LRTC_B_HUNDRED_YEAR_FLAG  7
`define LRTC_B_FMT   6
`define LRTC_B_PM    5
`define LRTC_B_MASK  7
`define LRTC_B_OSC   7
`define LRTC_B_MEN_N 4
`define LRTC_B_TLS   2
`define LRTC_B_THS   1
`define LRTC_B_TAS   0
`define LRTC_B_MIP   5
`define LRTC_B_CLR   6
`define LRTC_B_TLF   2
`define LRTC_B_THF   1
`define LRTC_B_TAF   0
// reset values
`define LRTC_R_ONE   8'h01
`define LRTC_R_CTRL  8'h10
// timing
`define LRTC_TICK_NS 1000000000
`define LRTC_CLK_NS  5
// temperature code offsets in eighth degrees
`define LRTC_OFFS8_H 13'sh0074
`define LRTC_OFFS8_Z -13'sh002C
`endif

// File: inc/lrtc_pkg.sv
// types of the logger clock/alarm register page
// assumes lrtc_params.svh is on the include path
`default_nettype none
package lrtc_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } lrtc_bus_s;

  typedef struct packed {
    logic [31:0] div;
    logic [7:0]  sec;
    logic [7:0]  min;
    logic [7:0]  hr;
    logic [7:0]  wday;
    logic [7:0]  date;
    logic [7:0]  mon;
    logic [7:0]  yr;
    logic [7:0]  al_sec;
    logic [7:0]  al_min;
    logic [7:0]  al_hr;
    logic [7:0]  al_wday;
    logic [7:0]  t_low;
    logic [7:0]  t_high;
    logic [7:0]  rate;
    logic [7:0]  ctrl;
    logic [7:0]  temp_code;
    logic        timer_alarm_flag;
    logic        tlf;
    logic        thf;
    logic        mip;
    logic        sec_seen;
    logic        alarm_evt;
    logic        hit;
    logic [7:0]  rdata;
  } lrtc_state_s;
endpackage
`default_nettype wire

// File: core/lrtc_core.sv
// clock, calendar, alarm and mission-control registers
// assumes a one-cycle strobe bus master on core_clk_i
//
// Behaviour
// - hours bit 6 high selects 12-hour mode, low 24-hour.
// - in 12-hour mode hours bit 5 is PM.
// - in 24-hour mode hours bit 5 is the twenties digit.
// - weekday counts 1 to 7 and wraps.
// - February 29 in years 00 or divisible by four.
// - century flag toggles when year rolls 99 to 00.
// - four alarm registers, bit 7 of each masks its field.
// - masks select per second, minute, hour or day matching.
// - all masks clear matches seconds, minutes, hours, weekday.
// - every alarm sets the timer alarm flag.
// - temperature is one unsigned byte, eighth-degree steps.
// - below range gives 00h, above range gives FFh.
// - code is eight times temperature minus variant offset.
// - low threshold at 20Bh, high threshold at 20Ch.
// - sample interval holds minutes between conversions.
// - nonzero interval write starts mission if cleared and enabled.
// - control write ends a running mission and updates contents.
// - control layout fixed; bit 5 reads zero.
// - timer_search lets alarm answer conditional search.
// - time registers are BCD; fixed zero bits read zero.
// - osc_stop halts clock; one second must pass before start.
// - temp searches answer after threshold reached in mission.
`timescale 1ns/10ps
`default_nettype none
`include "lrtc_params.svh"

module lrtc_core #(
  parameter int TICK_CYCLES = `LRTC_TICK_NS / `LRTC_CLK_NS,
  parameter bit HIGH_RANGE  = 1'b1
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   sys_rst_i,
  input  wire lrtc_pkg::lrtc_bus_s    bus_i,
  input  wire logic                   log_cleared_i,
  input  wire logic                   conv_valid_i,
  input  wire logic signed [11:0]     temp8_i,
  output logic [7:0]                  rdata_o,
  output logic                        alarm_evt_o,
  output logic                        mission_active_o,
  output logic                        search_match_o
);
  import lrtc_pkg::*;

  // every property samples on the core clock and rests during reset
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);

  // ==========================================================
  // constants and helpers
  localparam logic signed [12:0] OFFS8 =
    HIGH_RANGE ? `LRTC_OFFS8_H : `LRTC_OFFS8_Z;
  localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
  localparam lrtc_state_s ST_RST = '{
    wday    : `LRTC_R_ONE,
    date    : `LRTC_R_ONE,
    mon     : `LRTC_R_ONE,
    ctrl    : `LRTC_R_CTRL,
    default : '0
  };

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic is_leap(input logic [7:0] y);
    if (y[4]) begin
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end else begin
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) ||
                (y[3:0] == 4'h8);
    end
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic [7:0] y);
    case (m[4:0])
      5'h02:   month_len = is_leap(y) ? 8'h29 : 8'h28;
      5'h04,
      5'h06,
      5'h09,
      5'h11:   month_len = 8'h30;
      default: month_len = 8'h31;
    endcase
  endfunction

  // ==========================================================
  // state
  lrtc_state_s        st_ff;
  lrtc_state_s        nxt_st;
  logic               tick;
  logic               c_min;
  logic               c_hr;
  logic               c_day;
  logic               c_mon;
  logic               c_yr;
  logic               alarm;
  logic               start_ok;
  logic signed [12:0] raw;
  logic [7:0]         code;

  // ==========================================================
  // temperature encoding
  always_comb begin
    raw = {temp8_i[11], temp8_i} - OFFS8;
    if (raw < 13'sh0000) begin
      code = 8'h00;
    end else if (raw > 13'sh00FF) begin
      code = 8'hFF;
    end else begin
      code = raw[7:0];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.alarm_evt = 1'b0;
    nxt_st.rdata     = 8'h00;
    tick             = 1'b0;
    c_min            = 1'b0;
    c_hr             = 1'b0;
    c_day            = 1'b0;
    c_mon            = 1'b0;
    c_yr             = 1'b0;
    alarm            = 1'b0;
    start_ok         = 1'b0;

    // one-second timebase, held at zero while stopped
    if (st_ff.ctrl[`LRTC_B_OSC]) begin
      nxt_st.div = '0;
    end else if (st_ff.div == TICK_LAST) begin
      nxt_st.div = '0;
      tick       = 1'b1;
    end else begin
      nxt_st.div = st_ff.div + 32'h1;
    end

    // BCD time and calendar
    if (tick) begin
      nxt_st.sec_seen = 1'b1;
      if (st_ff.sec == 8'h59) begin
        nxt_st.sec = 8'h00;
        c_min      = 1'b1;
      end else begin
        nxt_st.sec = bcd_inc(st_ff.sec);
      end
    end
    if (c_min) begin
      if (st_ff.min == 8'h59) begin
        nxt_st.min = 8'h00;
        c_hr       = 1'b1;
      end else begin
        nxt_st.min = bcd_inc(st_ff.min);
      end
    end
    if (c_hr) begin
      if (st_ff.hr[`LRTC_B_FMT]) begin
        if (st_ff.hr[4:0] == 5'h11) begin
          nxt_st.hr[4:0]        = 5'h12;
          nxt_st.hr[`LRTC_B_PM] = ~st_ff.hr[`LRTC_B_PM];
          c_day                 = st_ff.hr[`LRTC_B_PM];
        end else if (st_ff.hr[4:0] == 5'h12) begin
          nxt_st.hr[4:0] = 5'h01;
        end else begin
          nxt_st.hr[4:0] = 5'(bcd_inc({3'b000, st_ff.hr[4:0]}));
        end
      end else if (st_ff.hr[5:0] == 6'h23) begin
        nxt_st.hr[5:0] = 6'h00;
        c_day          = 1'b1;
      end else begin
        nxt_st.hr[5:0] = 6'(bcd_inc({2'b00, st_ff.hr[5:0]}));
      end
    end
    if (c_day) begin
      nxt_st.wday = (st_ff.wday == 8'h07) ? 8'h01 :
                    st_ff.wday + 8'h01;
      if (st_ff.date == month_len(st_ff.mon, st_ff.yr)) begin
        nxt_st.date = 8'h01;
        c_mon       = 1'b1;
      end else begin
        nxt_st.date = bcd_inc(st_ff.date);
      end
    end
    if (c_mon) begin
      if (st_ff.mon[4:0] == 5'h12) begin
        nxt_st.mon[4:0] = 5'h01;
        c_yr            = 1'b1;
      end else begin
        nxt_st.mon[4:0] = 5'(bcd_inc({3'b000, st_ff.mon[4:0]}));
      end
    end
    if (c_yr) begin
      if (st_ff.yr == 8'h99) begin
        nxt_st.yr               = 8'h00;
        nxt_st.mon[`LRTC_B_HUNDRED_YEAR_FLAG] = ~st_ff.mon[`LRTC_B_HUNDRED_YEAR_FLAG];
      end else begin
        nxt_st.yr = bcd_inc(st_ff.yr);
      end
    end

    // alarm against the freshly advanced time
    alarm = tick &&
      (st_ff.al_sec[`LRTC_B_MASK] ||
       ({1'b0, st_ff.al_sec[6:0]} == nxt_st.sec)) &&
      (st_ff.al_min[`LRTC_B_MASK] ||
       ({1'b0, st_ff.al_min[6:0]} == nxt_st.min)) &&
      (st_ff.al_hr[`LRTC_B_MASK] ||
       ({1'b0, st_ff.al_hr[6:0]} == nxt_st.hr)) &&
      (st_ff.al_wday[`LRTC_B_MASK] ||
       ({5'h00, st_ff.al_wday[2:0]} == nxt_st.wday));

    // a write to a time field wins over the same-cycle tick
    start_ok = log_cleared_i && !st_ff.ctrl[`LRTC_B_MEN_N] &&
               st_ff.sec_seen && !st_ff.mip;
    if (bus_i.wr) begin
      case (bus_i.addr)
        `LRTC_A_SEC:   nxt_st.sec     = bus_i.wdata & `LRTC_M_SEC;
        `LRTC_A_MIN:   nxt_st.min     = bus_i.wdata & `LRTC_M_SEC;
        `LRTC_A_HR:    nxt_st.hr      = bus_i.wdata & `LRTC_M_HR;
        `LRTC_A_WDAY:  nxt_st.wday    = bus_i.wdata & `LRTC_M_WDAY;
        `LRTC_A_DATE:  nxt_st.date    = bus_i.wdata & `LRTC_M_DATE;
        `LRTC_A_MON:   nxt_st.mon     = bus_i.wdata & `LRTC_M_MON;
        `LRTC_A_YR:    nxt_st.yr      = bus_i.wdata;
        `LRTC_A_ASEC:  nxt_st.al_sec  = bus_i.wdata;
        `LRTC_A_AMIN:  nxt_st.al_min  = bus_i.wdata;
        `LRTC_A_AHR:   nxt_st.al_hr   = bus_i.wdata;
        `LRTC_A_AWDAY: nxt_st.al_wday = bus_i.wdata & `LRTC_M_AWDAY;
        `LRTC_A_TLOW:  nxt_st.t_low   = bus_i.wdata;
        `LRTC_A_THIGH: nxt_st.t_high  = bus_i.wdata;
        `LRTC_A_RATE: begin
          nxt_st.rate = bus_i.wdata;
          if ((bus_i.wdata != 8'h00) && start_ok) begin
            nxt_st.mip = 1'b1;
          end
        end
        `LRTC_A_CTRL: begin
          nxt_st.ctrl = bus_i.wdata & `LRTC_M_CTRL;
          nxt_st.mip  = 1'b0;
          if (bus_i.wdata[`LRTC_B_OSC]) begin
            nxt_st.sec_seen = 1'b0;
          end
        end
        `LRTC_A_STAT: begin
          // flags accept only zero writes
          nxt_st.timer_alarm_flag = st_ff.timer_alarm_flag & bus_i.wdata[`LRTC_B_TAF];
          nxt_st.thf = st_ff.thf & bus_i.wdata[`LRTC_B_THF];
          nxt_st.tlf = st_ff.tlf & bus_i.wdata[`LRTC_B_TLF];
          nxt_st.mip = nxt_st.mip & bus_i.wdata[`LRTC_B_MIP];
        end
        default: ;
      endcase
    end

    // events set after the clear so a same-cycle event survives
    if (alarm) begin
      nxt_st.timer_alarm_flag = 1'b1;
    end
    nxt_st.alarm_evt = alarm;
    if (conv_valid_i) begin
      nxt_st.temp_code = code;
      if (st_ff.mip && (code <= st_ff.t_low)) begin
        nxt_st.tlf = 1'b1;
      end
      if (st_ff.mip && (code >= st_ff.t_high)) begin
        nxt_st.thf = 1'b1;
      end
    end
    nxt_st.hit = (nxt_st.ctrl[`LRTC_B_TAS] && nxt_st.timer_alarm_flag) ||
                 (nxt_st.ctrl[`LRTC_B_TLS] && nxt_st.tlf) ||
                 (nxt_st.ctrl[`LRTC_B_THS] && nxt_st.thf);

    // read data valid only in the cycle after the strobe
    if (bus_i.rd) begin
      case (bus_i.addr)
        `LRTC_A_SEC:   nxt_st.rdata = st_ff.sec;
        `LRTC_A_MIN:   nxt_st.rdata = st_ff.min;
        `LRTC_A_HR:    nxt_st.rdata = st_ff.hr;
        `LRTC_A_WDAY:  nxt_st.rdata = st_ff.wday;
        `LRTC_A_DATE:  nxt_st.rdata = st_ff.date;
        `LRTC_A_MON:   nxt_st.rdata = st_ff.mon;
        `LRTC_A_YR:    nxt_st.rdata = st_ff.yr;
        `LRTC_A_ASEC:  nxt_st.rdata = st_ff.al_sec;
        `LRTC_A_AMIN:  nxt_st.rdata = st_ff.al_min;
        `LRTC_A_AHR:   nxt_st.rdata = st_ff.al_hr;
        `LRTC_A_AWDAY: nxt_st.rdata = st_ff.al_wday;
        `LRTC_A_TLOW:  nxt_st.rdata = st_ff.t_low;
        `LRTC_A_THIGH: nxt_st.rdata = st_ff.t_high;
        `LRTC_A_RATE:  nxt_st.rdata = st_ff.rate;
        `LRTC_A_CTRL:  nxt_st.rdata = st_ff.ctrl;
        `LRTC_A_TEMP:  nxt_st.rdata = st_ff.temp_code;
        `LRTC_A_STAT: begin
          nxt_st.rdata                = 8'h00;
          nxt_st.rdata[`LRTC_B_CLR]   = log_cleared_i;
          nxt_st.rdata[`LRTC_B_MIP]   = st_ff.mip;
          nxt_st.rdata[`LRTC_B_TLF]   = st_ff.tlf;
          nxt_st.rdata[`LRTC_B_THF]   = st_ff.thf;
          nxt_st.rdata[`LRTC_B_TAF]   = st_ff.timer_alarm_flag;
        end
        default:       nxt_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o          = st_ff.rdata;
  assign alarm_evt_o      = st_ff.alarm_evt;
  assign mission_active_o = st_ff.mip;
  assign search_match_o   = st_ff.hit;

  // ==========================================================
  // assertions
  logic no_wr;
  assign no_wr = !bus_i.wr;

  pm_toggle_a: assert property (
    (c_hr && st_ff.hr[`LRTC_B_FMT] && st_ff.hr[4:0] == 5'h11 && no_wr)
    |=> (st_ff.hr[`LRTC_B_PM] != $past(st_ff.hr[`LRTC_B_PM])))
    else $error("pm bit did not toggle at 11 to 12");

  hour_wrap_a: assert property (
    (c_hr && !st_ff.hr[`LRTC_B_FMT] && st_ff.hr[5:0] == 6'h19 && no_wr)
    |=> (st_ff.hr[5:0] == 6'h20))
    else $error("24h twenties digit not set");

  wday_wrap_a: assert property (
    (c_day && st_ff.wday == 8'h07 && no_wr) |=> (st_ff.wday == 8'h01))
    else $error("weekday did not wrap to 1");

  leap_day_a: assert property (
    (c_day && st_ff.mon[4:0] == 5'h02 && st_ff.date == 8'h28 &&
     is_leap(st_ff.yr) && no_wr) |=> (st_ff.date == 8'h29))
    else $error("leap day skipped");

  century_a: assert property (
    (c_yr && st_ff.yr == 8'h99 && no_wr)
    |=> (st_ff.mon[`LRTC_B_HUNDRED_YEAR_FLAG] != $past(st_ff.mon[`LRTC_B_HUNDRED_YEAR_FLAG])))
    else $error("century flag not toggled");

  every_sec_a: assert property (
    (tick && st_ff.al_sec[7] && st_ff.al_min[7] && st_ff.al_hr[7] &&
     st_ff.al_wday[7]) |=> alarm_evt_o)
    else $error("masked alarm missed a second");

  flag_set_a: assert property (
    alarm_evt_o |-> st_ff.timer_alarm_flag)
    else $error("alarm without timer flag");

  alarm_tick_a: assert property (
    alarm_evt_o |-> ($past(st_ff.div) == TICK_LAST))
    else $error("alarm outside a second update");

  clamp_low_a: assert property (
    (conv_valid_i && raw < 13'sh0000) |=> (st_ff.temp_code == 8'h00))
    else $error("low out of range code wrong");

  start_a: assert property (
    (bus_i.wr && bus_i.addr == `LRTC_A_RATE && bus_i.wdata != 8'h00 &&
     start_ok) |=> mission_active_o)
    else $error("mission did not start");

  ctrl_end_a: assert property (
    (bus_i.wr && bus_i.addr == `LRTC_A_CTRL)
    |=> (!mission_active_o && st_ff.ctrl[5] == 1'b0))
    else $error("control write kept mission or bit 5");

  osc_hold_a: assert property (
    st_ff.ctrl[`LRTC_B_OSC] |=> !alarm_evt_o [*2])
    else $error("clock advanced while stopped");

  alarm_seen_c: cover property (alarm_evt_o);
  mission_c:    cover property ($rose(mission_active_o));
  century_c:    cover property (c_yr && st_ff.yr == 8'h99);
  search_c:     cover property ($rose(search_match_o));
endmodule

`default_nettype wire

// File: testbench/lrtc_host_model.sv
// host-side register master for the logger clock page
// assumes one-cycle strobes and read data only in the cycle after rd
`timescale 1ns/10ps
`default_nettype none

module lrtc_host_model (
  input  wire logic                 core_clk_i,
  input  wire logic [7:0]           rdata_i,
  output var  lrtc_pkg::lrtc_bus_s  bus_o
);
  import lrtc_pkg::*;

  initial bus_o = '0;

  // ==========================================================
  // bus cycles
  // released lines show inverted values, not the last ones
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk_i);
    bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    bus_o <= '{addr: a, wdata: 8'h5A, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk_i);
    bus_o <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    #1 d = rdata_i;
  endtask
endmodule
`default_nettype wire

// File: testbench/lrtc_core_tb.sv
// self-checking bench of the logger clock/alarm register page
// assumes lrtc_pkg compiled first and lrtc_params.svh on the include path
`timescale 1ns/10ps
`default_nettype none

module lrtc_core_tb;
  import lrtc_pkg::*;
  localparam int TICK = 20;

  logic              core_clk_i = 1'b0;
  logic              sys_rst_i  = 1'b1;
  lrtc_bus_s         bus;
  logic              log_cleared = 1'b1;
  logic              conv_valid  = 1'b0;
  logic signed [11:0] temp8      = 12'sh000;
  logic [7:0]        rdata;
  logic              alarm_evt;
  logic              mission;
  logic              search;
  logic [7:0]        acnt = 8'h00;
  int                err_count = 0;
  int                checked   = 0;

  // ==========================================================
  // rows: address, write data, read-back
  logic [31:0] rows [15] = '{32'h0200FF7F, 32'h0201FF7F, 32'h0202FF7F, 32'h0203FF07, 32'h0204FF3F,
    32'h0205FF9F, 32'h02069999, 32'h02078585, 32'h02088080, 32'h0209D2D2, 32'h020AFF87,
    32'h020B4444, 32'h020CE4E4, 32'h020EFFDF, 32'h0215AA00};
  logic [11:0] temps [6] = '{12'd100, 12'd116, 12'd117, 12'd184, 12'd370, 12'd371};
  logic [7:0]  codes [6] = '{8'h00, 8'h00, 8'h01, 8'h44, 8'hFE, 8'hFF};

  lrtc_core #(.TICK_CYCLES(TICK), .HIGH_RANGE(1'b1)) i_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .log_cleared_i(log_cleared),
    .conv_valid_i(conv_valid), .temp8_i(temp8), .rdata_o(rdata), .alarm_evt_o(alarm_evt),
    .mission_active_o(mission), .search_match_o(search));

  lrtc_host_model i_host (.core_clk_i(core_clk_i), .rdata_i(rdata), .bus_o(bus));

  initial begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    if (alarm_evt === 1'b1) acnt <= acnt + 8'h01;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic settle();
    @(posedge core_clk_i);
    #1;
  endtask

  // preset time, let exactly one second pass, stop, compare
  task automatic roll(input logic [55:0] t, input logic [55:0] e);
    i_host.wr(16'h020E, 8'h80);
    for (int i = 0; i < 7; i++) i_host.wr(16'h0200 + 16'(i), t[55-8*i -: 8]);
    i_host.wr(16'h020E, 8'h00);
    repeat (TICK + 2) @(posedge core_clk_i);
    i_host.wr(16'h020E, 8'h80);
    for (int i = 0; i < 7; i++) rc(16'h0200 + 16'(i), e[55-8*i -: 8]);
  endtask

  task automatic set_al(input logic [31:0] v);
    for (int i = 0; i < 4; i++) i_host.wr(16'h0207 + 16'(i), v[31-8*i -: 8]);
  endtask

  // timer search on while running; leaves it on after stopping
  task automatic run(input int n, input logic [7:0] exp);
    acnt = 8'h00;
    i_host.wr(16'h020E, 8'h01);
    repeat (n * TICK + 3) @(posedge core_clk_i);
    i_host.wr(16'h020E, 8'h81);
    settle();
    chk(acnt, exp);
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    test_done();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge core_clk_i);
    #1 chk({5'h00, alarm_evt, mission, search}, 8'h00);
    @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rc(16'h020E, 8'h10);
    i_host.wr(16'h020E, 8'h00);
    i_host.wr(16'h020D, 8'h05);
    settle();
    chk({7'h00, mission}, 8'h00);
    rc(16'h0200, 8'h00);
    rc(16'h0203, 8'h01);
    rc(16'h0204, 8'h01);
    rc(16'h0205, 8'h01);
    repeat (TICK) @(posedge core_clk_i);
    log_cleared <= 1'b0;
    i_host.wr(16'h020D, 8'h05);
    settle();
    chk({7'h00, mission}, 8'h00);
    @(posedge core_clk_i);
    log_cleared <= 1'b1;
    i_host.wr(16'h020D, 8'h00);
    settle();
    chk({7'h00, mission}, 8'h00);
    i_host.wr(16'h020E, 8'h10);
    i_host.wr(16'h020D, 8'h06);
    settle();
    chk({7'h00, mission}, 8'h00);
    i_host.wr(16'h020E, 8'h04);
    i_host.wr(16'h020D, 8'h07);
    settle();
    chk({7'h00, mission}, 8'h01);
    rc(16'h020D, 8'h07);
    i_host.wr(16'h020B, 8'h44);
    i_host.wr(16'h020C, 8'hE4);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk_i);
      conv_valid <= 1'b1;
      temp8      <= temps[i];
      @(posedge core_clk_i);
      conv_valid <= 1'b0;
      rc(16'h0211, codes[i]);
    end
    // first codes at or below the low threshold, last ones at or above the high one
    chk({7'h00, search}, 8'h01);
    rc(16'h0214, 8'h66);
    i_host.wr(16'h020E, 8'h04);
    settle();
    chk({7'h00, mission}, 8'h00);
    i_host.wr(16'h020E, 8'h80);
    foreach (rows[i]) begin
      i_host.wr(rows[i][31:16], rows[i][15:8]);
      rc(rows[i][31:16], rows[i][7:0]);
    end
    roll(56'h59592307280204, 56'h00000001290204);
    roll(56'h59592307280205, 56'h00000001010305);
    roll(56'h59592301280200, 56'h00000002290200);
    roll(56'h59592303311299, 56'h00000004018100);
    roll(56'h59592303319299, 56'h00000004010100);
    roll(56'h59597101100510, 56'h00005202110510);
    roll(56'h59595101100510, 56'h00007201100510);
    roll(56'h59591901100510, 56'h00002001100510);
    for (int i = 0; i < 4; i++) i_host.wr(16'h0200 + 16'(i), (i == 3) ? 8'h01 : 8'h00);
    i_host.wr(16'h0214, 8'h00);
    set_al(32'h80808080);
    run(3, 8'h03);
    rc(16'h0214, 8'h41);
    chk({7'h00, search}, 8'h01);
    i_host.wr(16'h0214, 8'h00);
    settle();
    chk({7'h00, search}, 8'h00);
    set_al(32'h05808080);
    run(4, 8'h01);
    set_al(32'h08000081);
    run(2, 8'h01);
    set_al(32'h10008081);
    run(2, 8'h01);
    i_host.wr(16'h0214, 8'h00);
    set_al(32'h12000001);
    run(2, 8'h01);
    rc(16'h0214, 8'h41);
    set_al(32'h14000002);
    run(2, 8'h00);
    chk({7'h00, search}, 8'h01);
    // mid-run reset: search is high here and must drop with everything else
    @(posedge core_clk_i);
    sys_rst_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    #1 chk({5'h00, alarm_evt, mission, search}, 8'h00);
    rc(16'h020E, 8'h10);
    rc(16'h0214, 8'h40);
    rc(16'h0203, 8'h01);
    test_done();
  end
endmodule
`default_nettype wire
